// ### rtl/ifql_regs.svh
`ifndef IFQL_REGS_SVH
`define IFQL_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define IFQL_OFS_TXCS 8'h00
`define IFQL_OFS_RXCS 8'h04
`define IFQL_OFS_TXDAT 8'h08
`define IFQL_OFS_RXDAT 8'h0c
`define IFQL_OFS_IRQST 8'h10
`define IFQL_OFS_IRQCLR 8'h14
`define IFQL_OFS_IRQEN 8'h18

// ==========================================================
// Field positions of the queue control and status words
`define IFQL_BIT_MODE 14
`define IFQL_BIT_RUN 13
`define IFQL_CNT_HI 12
`define IFQL_CNT_LO 8
`define IFQL_BIT_FLAG 7
`define IFQL_BIT_CLR 6
`define IFQL_BIT_IEN 5
`define IFQL_LVL_HI 4
`define IFQL_LVL_LO 0

// ==========================================================
// Interrupt status, clear and enable layout
`define IFQL_IRQ_TXLVL 0
`define IFQL_IRQ_RXLVL 1
`define IFQL_IRQ_TXOVF 2
`define IFQL_IRQ_RXOVF 3

// ==========================================================
// Depth and reset values
`define IFQL_ENTRIES 16
`define IFQL_DEPTH 5'h10
`define IFQL_RST_CNT 5'h00
`define IFQL_RST_PTR 4'h0
`define IFQL_RST_BYTE 8'h00
`define IFQL_RST_WORD 32'h0000_0000

`endif

// ### rtl/ifql_pkg.sv
`default_nettype none

// ==========================================================
// Shared types
package ifql_pkg;
  typedef logic [4:0] ifql_cnt_t;
  typedef logic [3:0] ifql_ptr_t;
  typedef logic [7:0] ifql_byte_t;
endpackage : ifql_pkg

`default_nettype wire

// ### rtl/ifql_mem.sv
`include "ifql_regs.svh"
`default_nettype none

// ==========================================================
// Byte store, registered read with write bypass
module ifql_mem (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Write side
  input wire logic wr_en_i,
  input wire ifql_pkg::ifql_ptr_t wr_addr_i,
  input wire ifql_pkg::ifql_byte_t wr_data_i,
  // Read side
  input wire ifql_pkg::ifql_ptr_t rd_addr_i,
  output var ifql_pkg::ifql_byte_t rd_data_o
);

  ifql_pkg::ifql_byte_t mem_q [`IFQL_ENTRIES];
  wire bypass_w;

  // Bypass so a byte written into an empty queue is visible at once
  assign bypass_w = wr_en_i & (wr_addr_i == rd_addr_i);

  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_data_o <= `IFQL_RST_BYTE;
    end else begin
      rd_data_o <= bypass_w ? wr_data_i : mem_q[rd_addr_i];
    end
  end

endmodule : ifql_mem

`default_nettype wire

// ### rtl/ifql_top.sv
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`include "ifql_regs.svh"
`default_nettype none

// ==========================================================
// Notes on behaviour
// [RL1] Writing one to the transmit clear bit clears its flag; zero ignored; reads zero.
// [RL2] Transmit flag raises the interrupt only while its enable bit is one.
// [RL3] Transmit flag sets whenever transmit count is at or below its threshold.
// [RL4] Receive run bit zero forces receive pointers to zero and holds queue.
// [RL5] Receive count in bits 12..8 gives stored bytes, 16 at most.
// [RL6] Receive flag stays set until software writes one to its clear bit.
// [RL7] Receive flag raises the interrupt only while its enable bit is one.
// [RL8] Receive flag sets whenever receive count is at or above its threshold.
// [RL9] Zero receive threshold sets the receive flag as soon as queue runs.
// [RL10] Software should set the receive threshold no later than the run bit.
// [RL11] Bits 15..14 of the receive control word read zero, writes ignored.
// [RL12] Global queue mode bit must be one for either queue to operate.
// [RL13] Transmit run bit zero forces transmit pointers to zero and holds queue.
// [RL14] Transmit count uses the same encoding and resets to zero.
// [RL15] Thresholds compared every cycle; interrupt is OR of flag AND enable.
// [RL16] Each queue holds sixteen bytes; count follows pushes and pops.
module ifql_top (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output var logic [31:0] wb_dat_o,
  output var logic wb_ack_o,
  // Received bytes from the shift engine
  input wire logic rx_push_i,
  input wire logic [7:0] rx_byte_i,
  output var logic rx_ready_o,
  // Bytes for the shift engine to send
  input wire logic tx_pop_i,
  output wire ifql_pkg::ifql_byte_t tx_byte_o,
  output var logic tx_valid_o,
  // Interrupt
  output var logic irq_o
);

  // ==========================================================
  // Declarations; index 0 is transmit, index 1 is receive
  logic mode_q;
  logic [1:0] run_q;
  logic [1:0] ien_q;
  logic [1:0] flag_q;
  logic [1:0] ovf_q;
  logic [1:0] oen_q;
  logic [1:0] vld_q;
  logic [1:0] rdy_q;
  ifql_pkg::ifql_cnt_t lvl_q [2];
  ifql_pkg::ifql_cnt_t cnt_q [2];
  ifql_pkg::ifql_ptr_t wp_q [2];
  ifql_pkg::ifql_ptr_t rp_q [2];

  wire mode_d;
  wire irq_d;
  wire [1:0] run_d;
  wire [1:0] ien_d;
  wire [1:0] flag_d;
  wire [1:0] ovf_d;
  wire [1:0] oen_d;
  wire [1:0] on_w;
  wire [1:0] on_d;
  wire [1:0] push_w;
  wire [1:0] pop_w;
  wire [1:0] dpush_w;
  wire [1:0] dpop_w;
  wire [1:0] set_w;
  wire [1:0] clr_w;
  wire [1:0] ovs_w;
  wire [1:0] ovc_w;
  wire [1:0] vld_d;
  wire [1:0] rdy_d;
  wire [1:0] wr_cs;
  wire ifql_pkg::ifql_cnt_t lvl_d [2];
  wire ifql_pkg::ifql_cnt_t cnt_d [2];
  wire ifql_pkg::ifql_ptr_t wp_d [2];
  wire ifql_pkg::ifql_ptr_t rp_d [2];
  wire ifql_pkg::ifql_byte_t in_w [2];
  wire ifql_pkg::ifql_byte_t rd_w [2];
  wire [15:0] cs_w [2];

  wire req_w;
  wire acc_w;
  wire wr_w;
  wire rd_w_acc;
  wire sel_lo;
  wire sel_hi;
  wire hit_txcs;
  wire hit_rxcs;
  wire hit_txd;
  wire hit_rxd;
  wire hit_st;
  wire hit_clr;
  wire hit_en;
  wire wr_txd;
  wire rd_rxd;
  wire wr_en;
  wire wr_clr;
  wire [31:0] rdata_w;

  // ==========================================================
  // Bus decode
  // Effects land on the edge where the master sees ack, never earlier
  assign req_w = wb_cyc_i & wb_stb_i;
  assign acc_w = req_w & wb_ack_o;
  assign wr_w = acc_w & wb_we_i;
  assign rd_w_acc = acc_w & ~wb_we_i;
  assign sel_lo = wb_sel_i[0];
  assign sel_hi = wb_sel_i[1];
  assign hit_txcs = wb_adr_i == `IFQL_OFS_TXCS;
  assign hit_rxcs = wb_adr_i == `IFQL_OFS_RXCS;
  assign hit_txd = wb_adr_i == `IFQL_OFS_TXDAT;
  assign hit_rxd = wb_adr_i == `IFQL_OFS_RXDAT;
  assign hit_st = wb_adr_i == `IFQL_OFS_IRQST;
  assign hit_clr = wb_adr_i == `IFQL_OFS_IRQCLR;
  assign hit_en = wb_adr_i == `IFQL_OFS_IRQEN;
  assign wr_cs = {wr_w & hit_rxcs, wr_w & hit_txcs};
  assign wr_txd = wr_w & hit_txd & sel_lo;
  assign rd_rxd = rd_w_acc & hit_rxd;
  assign wr_en = wr_w & hit_en & sel_lo;
  assign wr_clr = wr_w & hit_clr & sel_lo;

  // ==========================================================
  // Read data
  // [RL11] Reserved bits read zero
  assign rdata_w = hit_txcs ? {16'h0000, cs_w[0]} :
                   hit_rxcs ? {16'h0000, cs_w[1]} :
                   hit_rxd ? {24'h00_0000, vld_q[1] ? rd_w[1] : `IFQL_RST_BYTE} :
                   hit_st ? {28'h000_0000, ovf_q, flag_q} :
                   hit_en ? {28'h000_0000, oen_q, ien_q} :
                   `IFQL_RST_WORD;

  // ==========================================================
  // Producers and consumers
  assign push_w = {rx_push_i, wr_txd};
  assign pop_w = {rd_rxd, tx_pop_i};
  assign in_w[0] = wb_dat_i[7:0];
  assign in_w[1] = rx_byte_i;
  // [RL12] Global mode gates both queues
  assign mode_d = (wr_cs[0] & sel_hi) ? wb_dat_i[`IFQL_BIT_MODE] : mode_q;

  // ==========================================================
  // Per-queue logic
  for (genvar g = 0; g < 2; g++) begin : g_q
    assign on_w[g] = mode_q & run_q[g];
    assign on_d[g] = mode_d & run_d[g];
    assign run_d[g] = (wr_cs[g] & sel_hi) ? wb_dat_i[`IFQL_BIT_RUN] : run_q[g];
    assign lvl_d[g] = (wr_cs[g] & sel_lo) ? wb_dat_i[`IFQL_LVL_HI:`IFQL_LVL_LO] : lvl_q[g];
    assign ien_d[g] = (wr_cs[g] & sel_lo) ? wb_dat_i[`IFQL_BIT_IEN] :
                      wr_en ? wb_dat_i[`IFQL_IRQ_TXLVL + g] : ien_q[g];
    assign oen_d[g] = wr_en ? wb_dat_i[`IFQL_IRQ_TXOVF + g] : oen_q[g];

    // [RL16] Push when not full, pop when not empty
    assign dpush_w[g] = push_w[g] & on_w[g] & (cnt_q[g] != `IFQL_DEPTH);
    assign dpop_w[g] = pop_w[g] & on_w[g] & (cnt_q[g] != `IFQL_RST_CNT);
    assign ovs_w[g] = push_w[g] & on_w[g] & (cnt_q[g] == `IFQL_DEPTH);

    // [RL4] [RL13] Held at zero while not running
    assign cnt_d[g] = !on_w[g] ? `IFQL_RST_CNT :
                      cnt_q[g] + {4'h0, dpush_w[g]} - {4'h0, dpop_w[g]};
    assign wp_d[g] = !on_w[g] ? `IFQL_RST_PTR : wp_q[g] + {3'h0, dpush_w[g]};
    assign rp_d[g] = !on_w[g] ? `IFQL_RST_PTR : rp_q[g] + {3'h0, dpop_w[g]};
    assign vld_d[g] = on_d[g] & (cnt_d[g] != `IFQL_RST_CNT);
    assign rdy_d[g] = on_d[g] & (cnt_d[g] != `IFQL_DEPTH);

    // [RL15] Compared every cycle
    if (g == 0) begin : g_le
      // [RL3] Transmit at or below
      assign set_w[g] = on_w[g] & (cnt_q[g] <= lvl_q[g]);
    end else begin : g_ge
      // [RL8] [RL9] Receive at or above
      assign set_w[g] = on_w[g] & (cnt_q[g] >= lvl_q[g]);
    end

    // [RL1] [RL6] Write-one clears, a set in the same cycle wins
    assign clr_w[g] = sel_lo & ((wr_cs[g] & wb_dat_i[`IFQL_BIT_CLR]) |
                                (wr_clr & wb_dat_i[`IFQL_IRQ_TXLVL + g]));
    assign flag_d[g] = set_w[g] | (flag_q[g] & ~clr_w[g]);
    assign ovc_w[g] = wr_clr & wb_dat_i[`IFQL_IRQ_TXOVF + g];
    assign ovf_d[g] = ovs_w[g] | (ovf_q[g] & ~ovc_w[g]);

    // [RL1] [RL5] [RL14] Clear bit reads zero; count in 12..8
    assign cs_w[g] = {1'b0, (g == 0) ? mode_q : 1'b0, run_q[g], cnt_q[g],
                      flag_q[g], 1'b0, ien_q[g], lvl_q[g]};

    ifql_mem ifql_mem_inst (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .wr_en_i(dpush_w[g]),
      .wr_addr_i(wp_q[g]),
      .wr_data_i(in_w[g]),
      .rd_addr_i(rp_d[g]),
      .rd_data_o(rd_w[g])
    );
  end

  // ==========================================================
  // Interrupt
  // [RL2] [RL7] [RL15] OR of each flag gated by its enable
  assign irq_d = |({ovf_d, flag_d} & {oen_d, ien_d});
  assign tx_byte_o = rd_w[0];

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `IFQL_RST_WORD;
    end else begin
      wb_ack_o <= req_w & ~wb_ack_o;
      wb_dat_o <= (req_w & ~wb_ack_o) ? rdata_w : `IFQL_RST_WORD;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= 1'b0;
      run_q <= 2'b00;
      ien_q <= 2'b00;
      oen_q <= 2'b00;
      flag_q <= 2'b00;
      ovf_q <= 2'b00;
    end else begin
      mode_q <= mode_d;
      run_q <= run_d;
      ien_q <= ien_d;
      oen_q <= oen_d;
      flag_q <= flag_d;
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      lvl_q <= '{default: `IFQL_RST_CNT};
      cnt_q <= '{default: `IFQL_RST_CNT};
      wp_q <= '{default: `IFQL_RST_PTR};
      rp_q <= '{default: `IFQL_RST_PTR};
    end else begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      vld_q <= 2'b00;
      rdy_q <= 2'b00;
      irq_o <= 1'b0;
    end else begin
      vld_q <= vld_d;
      rdy_q <= rdy_d;
      irq_o <= irq_d;
    end
  end

  assign tx_valid_o = vld_q[0];
  assign rx_ready_o = rdy_q[1];

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence rx_start_s;
    !on_w[1] ##1 (on_w[1] && lvl_q[1] == 5'h00);
  endsequence

  sequence tx_clear_s;
    clr_w[0] && !set_w[0];
  endsequence

  tx_clear_a: assert property (tx_clear_s |=> !flag_q[0]) // [RL1]
    else $error("transmit flag survived a clear");

  tx_irq_a: assert property ((flag_q[0] && ien_q[0]) |-> irq_o) // [RL2]
    else $error("transmit flag with enable gave no interrupt");

  tx_set_a: assert property ((on_w[0] && cnt_q[0] <= lvl_q[0]) |=> flag_q[0]) // [RL3]
    else $error("transmit flag not set at level");

  rx_hold_a: assert property (!run_q[1] |=> (cnt_q[1] == 5'h00 && (run_q[1] || !rx_ready_o))) // [RL4]
    else $error("receive queue not held while stopped");

  rx_count_a: assert property ((on_w[1] && rx_push_i && !rd_rxd && cnt_q[1] != 5'h10) // [RL5]
    |=> cnt_q[1] == 5'($past(cnt_q[1]) + 5'h01))
    else $error("receive count missed a push");

  rx_sticky_a: assert property ((flag_q[1] && !clr_w[1]) |=> flag_q[1]) // [RL6]
    else $error("receive flag dropped without a clear");

  rx_irq_a: assert property (irq_o == |({ovf_q, flag_q} & {oen_q, ien_q})) // [RL7]
    else $error("interrupt output disagrees with flags");

  rx_set_a: assert property ((on_w[1] && cnt_q[1] >= lvl_q[1]) |=> flag_q[1]) // [RL8]
    else $error("receive flag not set at level");

  rx_start_a: assert property (rx_start_s |=> flag_q[1] ##1 (irq_o || !ien_q[1])) // [RL9]
    else $error("receive flag not raised on start");

  rx_resv_a: assert property ((wb_ack_o && !wb_we_i && wb_adr_i == `IFQL_OFS_RXCS) // [RL11]
    |-> wb_dat_o[15:14] == 2'b00)
    else $error("receive reserved bits not zero");

  mode_off_a: assert property (!mode_q |=> (cnt_q[0] == 5'h00 && cnt_q[1] == 5'h00)) // [RL12]
    else $error("queue ran with mode off");

  tx_hold_a: assert property (!run_q[0] ##1 !run_q[0] |-> !tx_valid_o) // [RL13]
    else $error("transmit valid while stopped");

  tx_bound_a: assert property (cnt_q[0] <= 5'h10 && cnt_q[1] <= 5'h10) // [RL14]
    else $error("count above sixteen");

  tx_pop_a: assert property ((on_w[0] && tx_pop_i && !wr_txd && cnt_q[0] != 5'h00) // [RL16]
    |=> cnt_q[0] == 5'($past(cnt_q[0]) - 5'h01))
    else $error("transmit count missed a pop");

  rx_clear_a: assert property ((clr_w[1] && !set_w[1]) |=> !flag_q[1]) // [RL6]
    else $error("receive flag survived a clear");

  rx_pop_a: assert property ((on_w[1] && rd_rxd && !rx_push_i && cnt_q[1] != 5'h00) // [RL16]
    |=> cnt_q[1] == 5'($past(cnt_q[1]) - 5'h01))
    else $error("receive count missed a pop");

  tx_count_a: assert property ((on_w[0] && wr_txd && !tx_pop_i && cnt_q[0] != 5'h10) // [RL16]
    |=> cnt_q[0] == 5'($past(cnt_q[0]) + 5'h01))
    else $error("transmit count missed a push");

  irq_off_a: assert property ((ien_q == 2'b00 && oen_q == 2'b00) |-> !irq_o) // [RL2]
    else $error("interrupt raised with all enables off");

  rx_overflow_a: assert property ((on_w[1] && rx_push_i && cnt_q[1] == 5'h10) |=> ovf_q[1]) // [RL16]
    else $error("receive push into full queue not flagged");

endmodule : ifql_top

`default_nettype wire

// ### tb/ifql_engine_model.sv
`default_nettype none

// ==========================================================
// Shift engine stand-in: pushes received bytes, pops bytes to send
module ifql_engine_model (
  // Clock
  input wire logic ref_clk_i,
  // Receive side
  output var logic rx_push_o,
  output var logic [7:0] rx_byte_o,
  // Transmit side
  input wire logic [7:0] tx_byte_i,
  output var logic tx_pop_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_push_o = 1'b0;
    rx_byte_o = 8'h00;
    tx_pop_o = 1'b0;
  end
  task automatic push_byte(input logic [7:0] b);
    @(posedge ref_clk_i);
    rx_push_o <= 1'b1;
    rx_byte_o <= b;
    @(posedge ref_clk_i);
    rx_push_o <= 1'b0;
    // Idle line shows no stale byte
    rx_byte_o <= ~b;
  endtask : push_byte
  // One byte a pop, taken at the sampling edge
  task automatic pop_byte(output logic [7:0] b);
    @(posedge ref_clk_i);
    tx_pop_o <= 1'b1;
    @(posedge ref_clk_i);
    b = tx_byte_i;
    tx_pop_o <= 1'b0;
  endtask : pop_byte
endmodule : ifql_engine_model

`default_nettype wire

// ### tb/ifql_top_tb.sv
`include "ifql_regs.svh"
`default_nettype none

module ifql_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, rx_push, rx_ready, tx_pop, tx_valid, irq;
  logic [7:0] wb_adr, rx_byte, tx_byte, b;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat, wb_rdat;
  int failures, compares;
  // ==========================================================
  // Design and far side
  ifql_top ifql_top_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .rx_push_i(rx_push), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready),
    .tx_pop_i(tx_pop), .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .irq_o(irq));
  ifql_engine_model ifql_engine_model_inst (.ref_clk_i(ref_clk_i), .rx_push_o(rx_push),
    .rx_byte_o(rx_byte), .tx_byte_i(tx_byte), .tx_pop_o(tx_pop));
  // ==========================================================
  // Compare and bus tasks
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk32
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk1
  // Waits on ack under a bound; a hung slave counts as a mismatch
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge ref_clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= 4'h3;
    n = 0;
    @(posedge ref_clk_i);
    while (wb_ack !== 1'b1 && n < 20) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 20) failures++;
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0000_0000, r);
    chk32(r, exp);
  endtask : rd
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    rd(`IFQL_OFS_TXCS, 32'h0000_0000);
    rd(`IFQL_OFS_RXCS, 32'h0000_0000);
    rd(`IFQL_OFS_IRQST, 32'h0000_0000);
    wr(8'h1c, 32'h0000_ffff);
    rd(8'h1c, 32'h0000_0000);
    chk1(irq, 1'b0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_rx();
    wr(`IFQL_OFS_TXCS, 32'h0000_4000);
    wr(`IFQL_OFS_RXCS, 32'h0000_e023);
    rd(`IFQL_OFS_RXCS, 32'h0000_2023);
    for (int i = 0; i < 3; i++) ifql_engine_model_inst.push_byte(8'ha0 + 8'(i));
    rd(`IFQL_OFS_RXCS, 32'h0000_23a3);
    chk1(irq, 1'b1);
    for (int i = 0; i < 3; i++) rd(`IFQL_OFS_RXDAT, 32'h0000_00a0 + i);
    rd(`IFQL_OFS_RXCS, 32'h0000_20a3);
    wr(`IFQL_OFS_RXCS, 32'h0000_2063);
    rd(`IFQL_OFS_RXCS, 32'h0000_2023);
    chk1(irq, 1'b0);
    for (int i = 0; i < 17; i++) ifql_engine_model_inst.push_byte(8'(i));
    rd(`IFQL_OFS_RXCS, 32'h0000_30a3);
    chk1(rx_ready, 1'b0);
    rd(`IFQL_OFS_IRQST, 32'h0000_000a);
    wr(`IFQL_OFS_IRQEN, 32'h0000_0000);
    rd(`IFQL_OFS_RXCS, 32'h0000_3083);
    chk1(irq, 1'b0);
    wr(`IFQL_OFS_IRQEN, 32'h0000_0008);
    chk1(irq, 1'b1);
    wr(`IFQL_OFS_IRQCLR, 32'h0000_0008);
    chk1(irq, 1'b0);
    rd(`IFQL_OFS_IRQST, 32'h0000_0002);
    wr(`IFQL_OFS_RXCS, 32'h0000_0003);
    rd(`IFQL_OFS_RXCS, 32'h0000_0083);
    $display("test rx done");
  endtask : test_rx
  task automatic test_rx_zero_level();
    wr(`IFQL_OFS_RXCS, 32'h0000_0040);
    rd(`IFQL_OFS_RXCS, 32'h0000_0000);
    // Level written with the run bit
    wr(`IFQL_OFS_RXCS, 32'h0000_2020);
    rd(`IFQL_OFS_RXCS, 32'h0000_20a0);
    chk1(irq, 1'b1);
    wr(`IFQL_OFS_RXCS, 32'h0000_0040);
    $display("test rx zero level done");
  endtask : test_rx_zero_level
  task automatic test_tx();
    wr(`IFQL_OFS_TXCS, 32'h0000_6022);
    rd(`IFQL_OFS_TXCS, 32'h0000_60a2);
    chk1(irq, 1'b1);
    for (int i = 0; i < 3; i++) wr(`IFQL_OFS_TXDAT, 32'h0000_00b0 + i);
    rd(`IFQL_OFS_TXCS, 32'h0000_63a2);
    wr(`IFQL_OFS_TXCS, 32'h0000_6062);
    rd(`IFQL_OFS_TXCS, 32'h0000_6322);
    chk1(irq, 1'b0);
    chk1(tx_valid, 1'b1);
    ifql_engine_model_inst.pop_byte(b);
    chk32({24'h0, b}, 32'h0000_00b0);
    rd(`IFQL_OFS_TXCS, 32'h0000_62a2);
    wr(`IFQL_OFS_TXCS, 32'h0000_6002);
    chk1(irq, 1'b0);
    for (int i = 1; i < 3; i++) begin
      ifql_engine_model_inst.pop_byte(b);
      chk32({24'h0, b}, 32'h0000_00b0 + i);
    end
    // Valid falls at the edge of the last pop; look one edge later
    @(posedge ref_clk_i);
    chk1(tx_valid, 1'b0);
    wr(`IFQL_OFS_TXDAT, 32'h0000_0055);
    wr(`IFQL_OFS_TXCS, 32'h0000_4002);
    rd(`IFQL_OFS_TXCS, 32'h0000_4082);
    chk1(tx_valid, 1'b0);
    // Clear while stopped, then fill past sixteen to raise the overflow
    wr(`IFQL_OFS_TXCS, 32'h0000_6040);
    for (int i = 0; i < 17; i++) wr(`IFQL_OFS_TXDAT, 32'(i));
    rd(`IFQL_OFS_TXCS, 32'h0000_7080);
    rd(`IFQL_OFS_IRQST, 32'h0000_0007);
    $display("test tx done");
  endtask : test_tx
  task automatic test_mode_off();
    wr(`IFQL_OFS_TXCS, 32'h0000_2000);
    // Flag left set earlier; with mode off nothing sets it again
    wr(`IFQL_OFS_RXCS, 32'h0000_2040);
    ifql_engine_model_inst.push_byte(8'h3c);
    rd(`IFQL_OFS_RXCS, 32'h0000_2000);
    chk1(rx_ready, 1'b0);
    $display("test mode off done");
  endtask : test_mode_off
  // ==========================================================
  // Clock, run and verdict
  task automatic stop_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #100us;
    failures++;
    stop_test();
  end
  initial begin
    failures = 0;
    compares = 0;
    rst_i = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat = 32'h0000_0000;
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_rx();
    test_rx_zero_level();
    test_tx();
    test_mode_off();
    stop_test();
  end
endmodule : ifql_top_tb

`default_nettype wire
